// ===== inc/mbt_pkg.sv
// Purpose: Shared constants and types for the bit, transfer and control executor
// Assumes: 32-bit APB data, byte addresses, one core clock
// Notes: Every offset, field position and cycle count, and the flag, stack pointer and select reset values, live here

package mbt_pkg;

   // ****************************************
   // Register map (byte addresses)
   // ****************************************
   localparam int unsigned APB_AW = 8;
   localparam logic [7:0] OFF_CMD = 8'h00;
   localparam logic [7:0] OFF_STATUS = 8'h04;
   localparam logic [7:0] OFF_REG_SEL = 8'h08;
   localparam logic [7:0] OFF_REG_VAL = 8'h0C;
   localparam logic [7:0] OFF_STACK_PTR = 8'h10;
   localparam logic [7:0] OFF_FLAGS = 8'h14;

   // ****************************************
   // Status register fields
   // ****************************************
   localparam int unsigned STAT_BUSY = 0;
   localparam int unsigned STAT_BAD_OP = 1;
   localparam int unsigned STAT_DROPPED = 2;

   // ****************************************
   // Status flag positions
   // ****************************************
   localparam int unsigned FLAG_C = 0;
   localparam int unsigned FLAG_Z = 1;
   localparam int unsigned FLAG_N = 2;
   localparam int unsigned FLAG_V = 3;
   localparam int unsigned FLAG_S = 4;
   localparam int unsigned FLAG_H = 5;
   localparam int unsigned FLAG_T = 6;
   localparam int unsigned FLAG_I = 7;

   // ****************************************
   // Reset values and data space layout
   // ****************************************
   localparam logic [7:0] FLAGS_RESET = 8'h00;
   localparam logic [7:0] SP_RESET = 8'h5F;
   localparam logic [3:0] REG_SEL_RESET = 4'h0;
   localparam int unsigned NUM_REGS = 16;
   localparam int unsigned IO_SIZE = 64;
   localparam logic [15:0] SRAM_BASE = 16'h0040;
   localparam int unsigned SRAM_DEPTH = 32;
   localparam logic [3:0] PTR_X_LO = 4'hA;
   localparam logic [3:0] PTR_Y_LO = 4'hC;
   localparam logic [3:0] PTR_Z_LO = 4'hE;

   // ****************************************
   // Cycle counts
   // ****************************************
   localparam logic [1:0] CYC_ONE = 2'h1;
   localparam logic [1:0] CYC_TWO = 2'h2;
   localparam logic [1:0] CYC_THREE = 2'h3;

   // ****************************************
   // Operations and command layout
   // ****************************************
   typedef enum logic [4:0] {
      OP_IDLE = 5'h00, OP_IO_SET = 5'h01, OP_IO_CLR = 5'h02, OP_BIT_TO_T = 5'h03,
      OP_T_TO_BIT = 5'h04, OP_FLAG_SET = 5'h05, OP_FLAG_CLR = 5'h06, OP_COPY = 5'h07,
      OP_IMM = 5'h08, OP_IND_RD = 5'h09, OP_IND_RD_INC = 5'h0A, OP_IND_RD_DEC = 5'h0B,
      OP_IND_WR = 5'h0C, OP_IND_WR_INC = 5'h0D, OP_IND_WR_DEC = 5'h0E, OP_DIR_RD = 5'h0F,
      OP_DIR_WR = 5'h10, OP_PORT_RD = 5'h11, OP_PORT_WR = 5'h12, OP_PUSH = 5'h13,
      OP_POP = 5'h14, OP_BREAK = 5'h15, OP_SLEEP = 5'h16, OP_WDT = 5'h17,
      OP_IRQ_ON = 5'h18, OP_IRQ_OFF = 5'h19
   } mbt_op_t;

   typedef struct packed {
      mbt_op_t op;         // [23:19]
      logic [3:0] rd;      // [18:15] destination register
      logic [3:0] rr;      // [14:11] source register
      logic [2:0] bitsel;  // [10:8] bit, flag or pointer select
      logic [7:0] imm;     // [7:0] constant, direct or I/O address
   } mbt_cmd_t;

   localparam int unsigned CMD_W = 24;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_EXEC = 2'b10
   } mbt_state_t;

endpackage

// ===== logic/mbt_apb_port.sv
// Purpose: APB slave handshake with one wait state
// Assumes: Read data and hit are combinational from the parent
// Notes: Writes take effect on the edge where pready is sampled high

`timescale 1ns/1ps

module mbt_apb_port (
   input wire logic pclk,           // Core clock
   input wire logic presetn,        // Asynchronous reset, active low
   input wire logic psel,           // APB select
   input wire logic penable,        // APB access phase
   input wire logic pwrite,         // APB direction
   input wire logic [31:0] rdata,   // Selected read data
   input wire logic hit,            // Address is mapped
   output logic pready,             // APB ready, registered
   output logic [31:0] prdata,      // APB read data, registered
   output logic pslverr,            // APB error, registered
   output logic wr_stb              // Write takes effect this edge
);

   logic access;

   // First access cycle; ready follows one cycle later
   assign access = psel & penable & ~pready;
   assign wr_stb = psel & penable & pready & pwrite & ~pslverr;

   // Ready, error and read data are captured together
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else begin
         pready <= access;
         pslverr <= access & ~hit;
         if (access && !pwrite && hit) begin
            prdata <= rdata;
         end else if (access) begin
            prdata <= 32'h0000_0000;
         end
      end
   end

endmodule

// ===== logic/mbt_exec.sv
// Purpose: Executes bit, flag, data transfer and control operations
// Assumes: Commands arrive over APB; data space, I/O and stack are internal
// Notes: One command at a time; a command written while busy is dropped
//
// Functional notes
// - I/O bit set forces one addressed I/O bit high, one cycle, flags kept.
// - I/O bit clear forces one addressed I/O bit low, one cycle, flags kept.
// - Bit to transfer copies a register bit into T, one cycle.
// - Transfer to bit writes T into a register bit, one cycle.
// - Single-cycle set or clear of each flag touches only that flag.
// - Indirect read takes one or two cycles; post-increment form takes two.
// - Pre-decrement read steps pointer down first, two or three cycles.
// - Indirect write, plain or post-increment, finishes in one cycle.
// - Pre-decrement write steps pointer down first, two cycles.
// - Direct read loads a register from a constant address, one cycle.
// - Direct write stores a register to a constant address, one cycle.
// - Port read and port write move bytes to and from I/O, one cycle.
// - Push stores a register on the stack in two cycles.
// - Pop loads the top stack byte into a register in two cycles.
// - Break issues in one cycle, raising a break request pulse.
// - Sleep issues in one cycle, raising a sleep request pulse.
// - Watchdog restart issues in one cycle, raising a restart pulse.
//
// The implementer's own choices: the APB register port and the register addresses.

`timescale 1ns/1ps

module mbt_exec #(
   parameter int unsigned REGS = mbt_pkg::NUM_REGS,
   parameter int unsigned SRAM_WORDS = mbt_pkg::SRAM_DEPTH
) (
   input wire logic pclk,                          // Core clock, 25 MHz
   input wire logic presetn,                       // Asynchronous reset, active low
   input wire logic psel,                          // APB select
   input wire logic penable,                       // APB access phase
   input wire logic pwrite,                        // APB direction
   input wire logic [mbt_pkg::APB_AW-1:0] paddr,   // APB byte address
   input wire logic [31:0] pwdata,                 // APB write data
   output logic pready,                            // APB ready
   output logic [31:0] prdata,                     // APB read data
   output logic pslverr,                           // APB error on unmapped address
   output logic break_req,                         // One-cycle break request
   output logic sleep_req,                         // One-cycle sleep request
   output logic wdt_restart                        // One-cycle watchdog restart
);

   localparam int unsigned SRAM_AW = $clog2(SRAM_WORDS);

   // ****************************************
   // Storage
   // ****************************************
   logic [7:0] wreg [REGS];
   logic [7:0] io_mem [mbt_pkg::IO_SIZE];
   logic [7:0] sram [SRAM_WORDS];
   logic [7:0] flags;
   logic [7:0] sp;
   logic [3:0] reg_sel;
   logic bad_op;
   logic dropped;

   // ****************************************
   // Sequencing state
   // ****************************************
   mbt_pkg::mbt_state_t state;
   mbt_pkg::mbt_cmd_t cmd;
   logic [1:0] cnt;
   logic [1:0] cyc_need;
   logic do_exec;

   // ****************************************
   // Bus side signals
   // ****************************************
   logic wr_stb;
   logic hit;
   logic [31:0] rdata;
   logic cmd_wr;

   // ****************************************
   // Datapath signals
   // ****************************************
   logic [3:0] ptr_lo;
   logic [3:0] ptr_hi;
   logic [15:0] ptr_val;
   logic [15:0] next_ptr;
   logic ptr_dec;
   logic [15:0] data_addr;
   logic in_io;
   logic in_sram;
   logic [SRAM_AW-1:0] sram_idx;
   logic [7:0] rd_byte;
   logic [7:0] src_byte;
   logic mem_rd;
   logic mem_wr;
   logic ptr_upd;

   // ****************************************
   // APB slave
   // ****************************************
   mbt_apb_port u_apb (
      .pclk(pclk),
      .presetn(presetn),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .rdata(rdata),
      .hit(hit),
      .pready(pready),
      .prdata(prdata),
      .pslverr(pslverr),
      .wr_stb(wr_stb)
   );

   // Address decode and read mux
   always_comb begin
      hit = 1'b1;
      rdata = 32'h0000_0000;
      if (paddr == mbt_pkg::OFF_CMD) begin
         rdata = {8'h00, cmd};
      end else if (paddr == mbt_pkg::OFF_STATUS) begin
         rdata[mbt_pkg::STAT_BUSY] = (state == mbt_pkg::ST_EXEC);
         rdata[mbt_pkg::STAT_BAD_OP] = bad_op;
         rdata[mbt_pkg::STAT_DROPPED] = dropped;
      end else if (paddr == mbt_pkg::OFF_REG_SEL) begin
         rdata[3:0] = reg_sel;
      end else if (paddr == mbt_pkg::OFF_REG_VAL) begin
         rdata[7:0] = wreg[reg_sel];
      end else if (paddr == mbt_pkg::OFF_STACK_PTR) begin
         rdata[7:0] = sp;
      end else if (paddr == mbt_pkg::OFF_FLAGS) begin
         rdata[7:0] = flags;
      end else begin
         hit = 1'b0;
      end
   end

   assign cmd_wr = wr_stb && (paddr == mbt_pkg::OFF_CMD);

   // ****************************************
   // Pointer and data space addressing
   // ****************************************
   // Pointer pair picked by the low bits of the bit field; two or three selects Z
   always_comb begin
      case (cmd.bitsel[1:0])
         2'h0: ptr_lo = mbt_pkg::PTR_X_LO;
         2'h1: ptr_lo = mbt_pkg::PTR_Y_LO;
         default: ptr_lo = mbt_pkg::PTR_Z_LO;
      endcase
      ptr_hi = ptr_lo + 4'h1;
      ptr_val = {wreg[ptr_hi], wreg[ptr_lo]};
   end

   assign ptr_dec = (cmd.op == mbt_pkg::OP_IND_RD_DEC) || (cmd.op == mbt_pkg::OP_IND_WR_DEC);

   mbt_ptr_step #(
      .W(16)
   ) u_step (
      .ptr(ptr_val),
      .dec(ptr_dec),
      .nxt(next_ptr)
   );

   // Effective data address; pre-decrement forms use the stepped pointer
   always_comb begin
      case (cmd.op)
         mbt_pkg::OP_IND_RD, mbt_pkg::OP_IND_RD_INC,
         mbt_pkg::OP_IND_WR, mbt_pkg::OP_IND_WR_INC: data_addr = ptr_val;
         mbt_pkg::OP_IND_RD_DEC, mbt_pkg::OP_IND_WR_DEC: data_addr = next_ptr;
         mbt_pkg::OP_DIR_RD, mbt_pkg::OP_DIR_WR: data_addr = {8'h00, cmd.imm};
         mbt_pkg::OP_PUSH: data_addr = {8'h00, sp};
         mbt_pkg::OP_POP: data_addr = {8'h00, sp + 8'h01};
         default: data_addr = 16'h0000;
      endcase
   end

   // I/O space sits at the bottom of the data space, SRAM above it
   always_comb begin
      in_io = data_addr < 16'(mbt_pkg::IO_SIZE);
      in_sram = (data_addr >= mbt_pkg::SRAM_BASE) &&
                (data_addr < (mbt_pkg::SRAM_BASE + 16'(SRAM_WORDS)));
      sram_idx = SRAM_AW'(data_addr - mbt_pkg::SRAM_BASE);
      if (in_io) begin
         rd_byte = io_mem[data_addr[5:0]];
      end else if (in_sram) begin
         rd_byte = sram[sram_idx];
      end else begin
         rd_byte = 8'h00;
      end
   end

   assign src_byte = wreg[cmd.rr];

   // Operation classes
   always_comb begin
      mem_rd = 1'b0;
      mem_wr = 1'b0;
      ptr_upd = 1'b0;
      case (cmd.op)
         mbt_pkg::OP_IND_RD, mbt_pkg::OP_DIR_RD, mbt_pkg::OP_POP: mem_rd = 1'b1;
         mbt_pkg::OP_IND_RD_INC, mbt_pkg::OP_IND_RD_DEC: begin
            mem_rd = 1'b1;
            ptr_upd = 1'b1;
         end
         mbt_pkg::OP_IND_WR, mbt_pkg::OP_DIR_WR, mbt_pkg::OP_PUSH: mem_wr = 1'b1;
         mbt_pkg::OP_IND_WR_INC, mbt_pkg::OP_IND_WR_DEC: begin
            mem_wr = 1'b1;
            ptr_upd = 1'b1;
         end
         default: begin
            mem_rd = 1'b0;
         end
      endcase
   end

   // ****************************************
   // Cycle budget per operation
   // ****************************************
   // The long form of a plain or pre-decrement read is spent on SRAM; I/O is fast
   always_comb begin
      case (cmd.op)
         mbt_pkg::OP_IND_RD: cyc_need = in_sram ? mbt_pkg::CYC_TWO : mbt_pkg::CYC_ONE;
         mbt_pkg::OP_IND_RD_INC: cyc_need = mbt_pkg::CYC_TWO;
         mbt_pkg::OP_IND_RD_DEC: cyc_need = in_sram ? mbt_pkg::CYC_THREE : mbt_pkg::CYC_TWO;
         mbt_pkg::OP_IND_WR_DEC: cyc_need = mbt_pkg::CYC_TWO;
         mbt_pkg::OP_PUSH: cyc_need = mbt_pkg::CYC_TWO;
         mbt_pkg::OP_POP: cyc_need = mbt_pkg::CYC_TWO;
         default: cyc_need = mbt_pkg::CYC_ONE;
      endcase
   end

   assign do_exec = (state == mbt_pkg::ST_EXEC) && (cnt == cyc_need);

   // ****************************************
   // Sequencer
   // ****************************************
   // Every effect lands at the last cycle so a pointer is never seen half-updated
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= mbt_pkg::ST_IDLE;
         cnt <= 2'h0;
      end else begin
         case (state)
            mbt_pkg::ST_IDLE: begin
               if (cmd_wr) begin
                  state <= mbt_pkg::ST_EXEC;
                  cnt <= mbt_pkg::CYC_ONE;
               end
            end
            mbt_pkg::ST_EXEC: begin
               if (do_exec) begin
                  state <= mbt_pkg::ST_IDLE;
                  cnt <= 2'h0;
               end else begin
                  cnt <= cnt + 2'h1;
               end
            end
            default: begin
               state <= mbt_pkg::ST_IDLE;
               cnt <= 2'h0;
            end
         endcase
      end
   end

   // Command capture only while idle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cmd <= '0;
      end else if (cmd_wr && state == mbt_pkg::ST_IDLE) begin
         cmd <= mbt_pkg::mbt_cmd_t'(pwdata[mbt_pkg::CMD_W-1:0]);
      end
   end

   // Sticky status; a new event beats a software clear in the same cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bad_op <= 1'b0;
         dropped <= 1'b0;
      end else begin
         if (do_exec && cmd.op > mbt_pkg::OP_IRQ_OFF) begin
            bad_op <= 1'b1;
         end else if (wr_stb && paddr == mbt_pkg::OFF_STATUS && pwdata[mbt_pkg::STAT_BAD_OP]) begin
            bad_op <= 1'b0;
         end
         if (cmd_wr && state == mbt_pkg::ST_EXEC) begin
            dropped <= 1'b1;
         end else if (wr_stb && paddr == mbt_pkg::OFF_STATUS && pwdata[mbt_pkg::STAT_DROPPED]) begin
            dropped <= 1'b0;
         end
      end
   end

   // Software register window select
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         reg_sel <= mbt_pkg::REG_SEL_RESET;
      end else if (wr_stb && paddr == mbt_pkg::OFF_REG_SEL) begin
         reg_sel <= pwdata[3:0];
      end
   end

   // ****************************************
   // Working registers
   // ****************************************
   // Destination write wins over a pointer update aimed at the same register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < REGS; i++) begin
            wreg[i] <= 8'h00;
         end
      end else if (do_exec) begin
         if (ptr_upd) begin
            {wreg[ptr_hi], wreg[ptr_lo]} <= next_ptr;
         end
         case (cmd.op)
            mbt_pkg::OP_T_TO_BIT: wreg[cmd.rd][cmd.bitsel] <= flags[mbt_pkg::FLAG_T];
            mbt_pkg::OP_COPY: wreg[cmd.rd] <= src_byte;
            mbt_pkg::OP_IMM: wreg[cmd.rd] <= cmd.imm;
            mbt_pkg::OP_PORT_RD: wreg[cmd.rd] <= io_mem[cmd.imm[5:0]];
            default: begin
               if (mem_rd) begin
                  wreg[cmd.rd] <= rd_byte;
               end
            end
         endcase
      end else if (wr_stb && paddr == mbt_pkg::OFF_REG_VAL && state == mbt_pkg::ST_IDLE) begin
         wreg[reg_sel] <= pwdata[7:0];
      end
   end

   // ****************************************
   // Status flags
   // ****************************************
   // Only the named flag moves; every other operation leaves flags alone
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flags <= mbt_pkg::FLAGS_RESET;
      end else if (do_exec) begin
         case (cmd.op)
            mbt_pkg::OP_BIT_TO_T: flags[mbt_pkg::FLAG_T] <= src_byte[cmd.bitsel];
            mbt_pkg::OP_FLAG_SET: flags[cmd.bitsel] <= 1'b1;
            mbt_pkg::OP_FLAG_CLR: flags[cmd.bitsel] <= 1'b0;
            mbt_pkg::OP_IRQ_ON: flags[mbt_pkg::FLAG_I] <= 1'b1;
            mbt_pkg::OP_IRQ_OFF: flags[mbt_pkg::FLAG_I] <= 1'b0;
            default: flags <= flags;
         endcase
      end else if (wr_stb && paddr == mbt_pkg::OFF_FLAGS && state == mbt_pkg::ST_IDLE) begin
         flags <= pwdata[7:0];
      end
   end

   // ****************************************
   // Stack pointer
   // ****************************************
   // Post-decrement push, pre-increment pop
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sp <= mbt_pkg::SP_RESET;
      end else if (do_exec && cmd.op == mbt_pkg::OP_PUSH) begin
         sp <= sp - 8'h01;
      end else if (do_exec && cmd.op == mbt_pkg::OP_POP) begin
         sp <= sp + 8'h01;
      end else if (wr_stb && paddr == mbt_pkg::OFF_STACK_PTR && state == mbt_pkg::ST_IDLE) begin
         sp <= pwdata[7:0];
      end
   end

   // ****************************************
   // I/O space and SRAM
   // ****************************************
   // I/O bytes; bit ops are read-modify-write of a single bit
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < mbt_pkg::IO_SIZE; i++) begin
            io_mem[i] <= 8'h00;
         end
      end else if (do_exec) begin
         case (cmd.op)
            mbt_pkg::OP_IO_SET: io_mem[cmd.imm[5:0]][cmd.bitsel] <= 1'b1;
            mbt_pkg::OP_IO_CLR: io_mem[cmd.imm[5:0]][cmd.bitsel] <= 1'b0;
            mbt_pkg::OP_PORT_WR: io_mem[cmd.imm[5:0]] <= src_byte;
            default: begin
               if (mem_wr && in_io) begin
                  io_mem[data_addr[5:0]] <= src_byte;
               end
            end
         endcase
      end
   end

   // SRAM has no reset; stores outside both spaces are ignored
   always_ff @(posedge pclk) begin
      if (do_exec && mem_wr && in_sram) begin
         sram[sram_idx] <= src_byte;
      end
   end

   // ****************************************
   // Control pulses
   // ****************************************
   // One cycle each, leaving the sleep, break and watchdog logic to act on them
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         break_req <= 1'b0;
         sleep_req <= 1'b0;
         wdt_restart <= 1'b0;
      end else begin
         break_req <= do_exec && cmd.op == mbt_pkg::OP_BREAK;
         sleep_req <= do_exec && cmd.op == mbt_pkg::OP_SLEEP;
         wdt_restart <= do_exec && cmd.op == mbt_pkg::OP_WDT;
      end
   end

endmodule

// ===== logic/mbt_ptr_step.sv
// Purpose: One-step increment or decrement of a pointer pair
// Assumes: Wraps modulo the pointer width
// Notes: Purely combinational

`timescale 1ns/1ps

module mbt_ptr_step #(
   parameter int unsigned W = 16
) (
   input wire logic [W-1:0] ptr, // Current pointer value
   input wire logic dec,         // High to step down, low to step up
   output logic [W-1:0] nxt      // Stepped pointer value
);

   // Step by one in the chosen direction
   always_comb begin
      if (dec) begin
         nxt = ptr - W'(1);
      end else begin
         nxt = ptr + W'(1);
      end
   end

endmodule

// ===== testbench/mbt_checker.sv
// Purpose: Port-level checks of the executor
// Assumes: One clock domain, reset active low
// Notes: Pulse checks assume commands are only written while idle
`timescale 1ns/1ps
module mbt_checker (
   input wire logic pclk, // Clock
   input wire logic presetn, // Reset, active low
   input wire logic psel, // Select
   input wire logic penable, // Access phase
   input wire logic pwrite, // Direction
   input wire logic [7:0] paddr, // Byte address
   input wire logic [31:0] pwdata, // Write data
   input wire logic pready, // Ready
   input wire logic [31:0] prdata, // Read data
   input wire logic pslverr, // Error
   input wire logic break_req, // Break pulse
   input wire logic sleep_req, // Sleep pulse
   input wire logic wdt_restart // Restart pulse
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic cmd_wr;
   // Command word accepted at this edge
   assign cmd_wr = psel && penable && pready && pwrite && paddr == mbt_pkg::OFF_CMD && !pslverr;
   AST_RDY_WAIT: assert property (psel && penable && !pready |=> pready) else $error("ready late");
   AST_RDY_ONE: assert property (pready |=> !pready) else $error("ready held");
   AST_RDY_CAUSE: assert property (pready |-> $past(psel && penable)) else $error("ready without access");
   AST_ERR_RDY: assert property (pslverr |-> pready) else $error("error without ready");
   AST_WR_ZERO: assert property (pready && pwrite |-> prdata == 32'h0000_0000) else $error("read data on write");
   AST_BRK: assert property (cmd_wr && pwdata[23:19] == mbt_pkg::OP_BREAK |-> ##2 break_req)
      else $error("break pulse missing");
   AST_SLP: assert property (cmd_wr && pwdata[23:19] == mbt_pkg::OP_SLEEP |-> ##2 sleep_req)
      else $error("sleep pulse missing");
   AST_WDT: assert property (cmd_wr && pwdata[23:19] == mbt_pkg::OP_WDT |-> ##2 wdt_restart)
      else $error("restart pulse missing");
   AST_PULSE: assert property (break_req || sleep_req || wdt_restart |=> !(break_req || sleep_req || wdt_restart))
      else $error("control pulse too long");
   cover property (cmd_wr);
   cover property (pslverr);
   cover property (break_req);
endmodule
bind mbt_exec mbt_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
   .break_req(break_req), .sleep_req(sleep_req), .wdt_restart(wdt_restart));

// ===== testbench/mbt_ctl_partner.sv
// Purpose: Stand-in for the break, sleep and watchdog controllers
// Assumes: Requests are one-cycle pulses
// Notes: Counts requests so the bench can compare them
`timescale 1ns/1ps
module mbt_ctl_partner (
   input wire logic pclk, // Clock
   input wire logic presetn, // Reset, active low
   input wire logic break_req, // Break request
   input wire logic sleep_req, // Sleep request
   input wire logic wdt_restart, // Watchdog restart
   output int n_brk, // Breaks seen
   output int n_slp, // Sleeps seen
   output int n_wdt // Restarts seen
);
   // Each pulse is one request; a long pulse would count many times
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         n_brk <= 0;
         n_slp <= 0;
         n_wdt <= 0;
      end else begin
         n_brk <= n_brk + int'(break_req);
         n_slp <= n_slp + int'(sleep_req);
         n_wdt <= n_wdt + int'(wdt_restart);
      end
   end
endmodule

// ===== testbench/test_mbt_exec.sv
// Purpose: Self-checking bench for the executor
// Assumes: APB slave answers after one wait state
// Notes: Model state lives in int arrays; data space and I/O share one array
`timescale 1ns/1ps
module test_mbt_exec;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, brk, slp, wdt, e;
   logic [7:0] paddr, lfsr;
   logic [31:0] pwdata, prdata, q;
   int fail_count, samples_checked, cyc, i, nb, ns, nw;
   int rf[16], ds[256], fl, sp;
   mbt_exec dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .break_req(brk), .sleep_req(slp),
      .wdt_restart(wdt));
   mbt_ctl_partner u_ptn (.pclk(pclk), .presetn(presetn), .break_req(brk), .sleep_req(slp), .wdt_restart(wdt),
      .n_brk(nb), .n_slp(ns), .n_wdt(nw));
   // Clock and hang guard
   always #20 pclk = ~pclk;
   always @(posedge pclk) begin
      cyc++;
      if (cyc > 20000) begin fail_count++; conclude(); end
   end
   task automatic conclude();
      $display("checked %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin fail_count++; $display("Error %0t: got %h want %h", $time, seen, exp); end
   endtask
   // One APB transfer; holds everything until pready is sampled high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk) penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      q = prdata; e = pslverr;
      psel <= 1'b0; penable <= 1'b0;
      @(posedge pclk);
   endtask
   function automatic logic [7:0] rnd();
      lfsr = {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
      return lfsr;
   endfunction
   // Step the model, issue one command, compare flags, stack pointer and destination
   task automatic op(input int o, rd, rr, b, imm);
      int pi, a, n;
      pi = b == 0 ? 10 : b == 1 ? 12 : 14;
      a = rf[pi] + 256 * rf[pi + 1] - (o == 11 || o == 14);
      if (o > 11 && o < 15) ds[a % 256] = rf[rr];
      n = a + (o == 10 || o == 13);
      if (o > 9 && o < 15 && o != 12) begin rf[pi] = n % 256; rf[pi + 1] = n / 256 % 256; end
      case (o)
         1: ds[imm % 64] |= 1 << b;
         2: ds[imm % 64] &= ~(1 << b);
         3: fl = fl & ~64 | ((rf[rr] >> b) & 1) << 6;
         4: rf[rd] = rf[rd] & ~(1 << b) | ((fl >> 6) & 1) << b;
         5: fl |= 1 << b;
         6: fl &= ~(1 << b);
         7: rf[rd] = rf[rr];
         8: rf[rd] = imm;
         9, 10, 11, 15: rf[rd] = ds[o == 15 ? imm : a % 256];
         16: ds[imm] = rf[rr];
         17: rf[rd] = ds[imm % 64];
         18: ds[imm % 64] = rf[rr];
         19: begin ds[sp] = rf[rr]; sp--; end
         20: begin sp++; rf[rd] = ds[sp]; end
         24: fl |= 128;
         25: fl &= 127;
         default: ;
      endcase
      apb(1'b1, mbt_pkg::OFF_CMD, {8'h00, o[4:0], rd[3:0], rr[3:0], b[2:0], imm[7:0]});
      do apb(1'b0, mbt_pkg::OFF_STATUS, 32'h0000_0000); while (q[0] !== 1'b0);
      apb(1'b0, mbt_pkg::OFF_FLAGS, 32'h0000_0000);
      chk(q, fl);
      apb(1'b0, mbt_pkg::OFF_STACK_PTR, 32'h0000_0000);
      chk(q, sp);
      apb(1'b1, mbt_pkg::OFF_REG_SEL, rd);
      apb(1'b0, mbt_pkg::OFF_REG_VAL, 32'h0000_0000);
      chk(q, rf[rd]);
   endtask
   // Main sequence
   initial begin
      pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0; lfsr = 8'h0E; sp = 95;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, 8'h18, 32'h0000_0000);
      chk({q[31:1], e}, 32'h0000_0001);
      for (i = 0; i < 7; i++) op(5, 0, 0, i, 0);
      for (i = 0; i < 7; i++) op(6, 0, 0, i, 0);
      op(24, 0, 0, 0, 0); op(25, 0, 0, 0, 0); op(0, 0, 0, 0, 0);
      for (i = 1; i < 8; i++) op(8, i, 0, 0, rnd());
      op(7, 9, 3, 0, 0); op(3, 0, 2, 5, 0); op(4, 4, 0, 1, 0);
      op(18, 0, 1, 0, 5); op(1, 0, 0, 7, 5); op(2, 0, 0, 0, 5); op(17, 6, 0, 0, 5);
      op(16, 0, 2, 0, 80); op(15, 8, 0, 0, 80);
      op(8, 10, 0, 0, 68); op(8, 11, 0, 0, 0); op(13, 0, 3, 0, 0); op(11, 5, 0, 0, 0);
      op(10, 12, 0, 0, 0); op(12, 0, 6, 0, 0); op(14, 0, 4, 0, 0); op(9, 7, 0, 0, 0);
      op(7, 1, 10, 0, 0); op(19, 0, 2, 0, 0); op(20, 13, 0, 0, 0);
      op(21, 0, 0, 0, 0); op(22, 0, 0, 0, 0); op(23, 0, 0, 0, 0);
      chk({nb[7:0], ns[7:0], nw[7:0]}, 32'h0001_0101);
      conclude();
   end
endmodule
